/* logic/inband_mgmt_pkg.sv */
// Constants, field layouts and types shared by the in-band management status logic
package inband_mgmt_pkg;
  // Register byte addresses
  localparam logic [15:0] CTRL_ADDR     = 16'h0104;  // Control: address check enable and tag
  localparam logic [15:0] STATUS_ADDR   = 16'h0110;  // Operation status, read only
  localparam logic [15:0] INT_STAT_ADDR = 16'h0114;  // Sticky event bits, write one to clear
  localparam logic [15:0] INT_MASK_ADDR = 16'h0118;  // Interrupt mask, same layout

  // Control register fields
  localparam int                CHK_EN_BIT    = 30;
  localparam logic              CHK_EN_RESET  = 1'b0;
  localparam logic [15:0]       TAG_RESET     = 16'h40FE;

  // Status register fields
  localparam int GOOD_BIT = 31;
  localparam int RESP_BIT = 30;
  localparam int EXEC_BIT = 29;
  localparam int AMIS_BIT = 14;
  localparam int FMT_BIT  = 13;
  localparam int CODE_BIT = 12;
  localparam int CMD_BIT  = 11;
  localparam int OVER_BIT = 10;
  localparam int LOC_MSB  = 6;
  localparam int LOC_W    = 7;
  // Bits that carry events into the interrupt unit
  localparam logic [31:0] EVENT_BITS = 32'hE000_7C00;

  // Frame layout, byte counts from the first byte
  localparam logic [9:0]  DA_LEN      = 10'h006;     // Destination address bytes
  localparam logic [9:0]  TAG_END     = 10'h00E;     // Tag occupies bytes 12 and 13
  localparam logic [9:0]  FMT_END     = 10'h010;     // Access format in bytes 14 and 15
  localparam logic [9:0]  CODE_END    = 10'h012;     // Access code in bytes 16 and 17
  localparam logic [9:0]  MAX_FRAME   = 10'h140;     // 320 bytes incl. zero pad and check sequence
  localparam logic [9:0]  CNT_FIRST   = 10'h001;
  localparam logic [9:0]  CNT_MAX     = 10'h3FF;

  // Expected header values
  localparam logic [15:0] ACCESS_FORMAT = 16'h9800;
  localparam logic [15:0] ACCESS_CODE_A = 16'h0001;
  localparam logic [15:0] ACCESS_CODE_B = 16'h0002;

  // Frame tracking states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FRAME = 4'b0010,
    ST_MGMT  = 4'b0100,
    ST_OTHER = 4'b1000
  } frame_state_type;
endpackage

/* logic/rx_byte_tracker.sv */
// Byte counter and two-byte shift window over the received frame stream
`timescale 1ns/1ps
module rx_byte_tracker (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rx_valid,
  input  wire logic       rx_sof,
  input  wire logic       rx_eof,
  input  wire logic [7:0] rx_data,
  output logic            took,
  output logic            last,
  output logic [9:0]      cnt,
  output logic [15:0]     word
);
  import inband_mgmt_pkg::*;

  typedef struct packed {
    logic        took;   // A byte was taken last cycle
    logic        last;   // That byte ended the frame
    logic [9:0]  cnt;    // Bytes taken so far in this frame
    logic [15:0] word;   // Two most recent bytes, newest low
  } trk_state_type;

  trk_state_type s_q;
  trk_state_type s_d;

  // Count saturates so an endless frame still reads as oversized
  always_comb begin
    s_d      = s_q;
    s_d.took = rx_valid;
    s_d.last = rx_valid & rx_eof;
    if (rx_valid) begin
      s_d.word = {s_q.word[7:0], rx_data};
      if (rx_sof) begin
        s_d.cnt = CNT_FIRST;
      end else if (s_q.cnt != CNT_MAX) begin
        s_d.cnt = s_q.cnt + CNT_FIRST;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign took = s_q.took;
  assign last = s_q.last;
  assign cnt  = s_q.cnt;
  assign word = s_q.word;
endmodule // rx_byte_tracker

/* logic/event_irq.sv */
// Sticky event bits with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module event_irq #(
  parameter int          W     = 32,
  parameter logic [31:0] VALID = 32'hFFFF_FFFF
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] ev,
  input  wire logic         clr_wr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      stat,
  output logic [W-1:0]      mask,
  output logic              irq
);
  typedef struct packed {
    logic [W-1:0] stat;  // Sticky events
    logic [W-1:0] mask;  // One enables the bit onto irq
  } irq_state_type;

  irq_state_type s_q;
  irq_state_type s_d;

  // A new event wins over a clear in the same cycle
  always_comb begin
    s_d = s_q;
    if (clr_wr) begin
      s_d.stat = s_q.stat & ~wdata;
    end
    s_d.stat = s_d.stat | (ev & VALID[W-1:0]);
    if (mask_wr) begin
      s_d.mask = wdata & VALID[W-1:0];
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat = s_q.stat;
  assign mask = s_q.mask;
  assign irq  = |(s_q.stat & s_q.mask);
endmodule // event_irq

/* logic/inband_mgmt_status.sv */
// In-band management status: frame checks, status flags, register port and interrupt
//
// What this block does
// - Bit 31 set on good management frame
// - Bit 30 set when response sent
// - Bit 29 set after all commands executed
// - Tag-matching frame clears response, execution, error flags
// - Bit 14 set on destination address mismatch
// - Address mismatch reported only with check enabled
// - Bit 13 set when format not 0x9800
// - Bit 12 set unless access code 1 or 2
// - Bit 11 set on unknown command code
// - Bit 10 set for frames above 320 bytes
// - Size counts zero pad and check sequence
// - No response for oversized frame
// - Bits 6:0 hold bad command position
// - With checking on, mismatching frames are discarded
`timescale 1ns/1ps
module inband_mgmt_status (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic [7:0]  rx_data,
  input  wire logic [47:0] switch_mac,
  input  wire logic        cmd_err,
  input  wire logic [inband_mgmt_pkg::LOC_MSB:0] cmd_err_loc,
  input  wire logic        exec_done,
  input  wire logic        resp_sent,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             frame_good,
  output logic             frame_drop,
  output logic             resp_block,
  output logic             irq
);
  import inband_mgmt_pkg::*;

  // Byte position within the MAC address, 0 is the most significant byte
  function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [9:0] n);
    logic [47:0] sh;
    sh = mac >> (6'(8) * (6'(DA_LEN) - 6'(n) - 6'(1)));
    return sh[7:0];
  endfunction

  // Accepted access code values
  function automatic logic code_ok(input logic [15:0] c);
    return (c == ACCESS_CODE_A) || (c == ACCESS_CODE_B);
  endfunction

  typedef struct packed {
    frame_state_type    st;       // Frame tracking state
    logic               chk_en;   // Destination address check enable
    logic [15:0]        tag;      // Tag that marks management frames
    logic               good;     // Good frame seen
    logic               resp;     // Response sent
    logic               exec;     // All commands executed
    logic               amis;     // Address mismatch error
    logic               fmt;      // Access format error
    logic               code;     // Access code error
    logic               cmd;      // Command code error
    logic               over;     // Oversize error
    logic [LOC_MSB:0]   loc;      // Position of the bad command code
    logic               addr_bad; // This frame failed the address check
    logic               hdr_bad;  // This frame failed a header check
    logic               big;      // This frame ran past the size limit
    logic               fgood;    // Good frame pulse
    logic               fdrop;    // Discarded frame pulse
    logic               rblock;   // Response forbidden for the current frame
    logic [31:0]        rdata;    // Read data, one cycle after the strobe
  } main_state_type;

  main_state_type s_q;
  main_state_type s_d;
  logic [31:0]    ev;            // Event pulses in status layout

  // Tracker outputs
  logic           took;
  logic           last;
  logic [9:0]     cnt;
  logic [15:0]    word;

  // Interrupt unit outputs
  logic [31:0]    int_stat;
  logic [31:0]    int_mask;

  // Status word as software sees it; unused bits are constant zero
  function automatic logic [31:0] status_word(input main_state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[GOOD_BIT] = s.good;
    w[RESP_BIT] = s.resp;
    w[EXEC_BIT] = s.exec;
    w[AMIS_BIT] = s.amis;
    w[FMT_BIT]  = s.fmt;
    w[CODE_BIT] = s.code;
    w[CMD_BIT]  = s.cmd;
    w[OVER_BIT] = s.over;
    w[LOC_MSB:0] = s.loc;
    return w;
  endfunction

  // Byte counting and header window
  rx_byte_tracker u_trk (
    .clk      (clk),
    .rst      (rst),
    .rx_valid (rx_valid),
    .rx_sof   (rx_sof),
    .rx_eof   (rx_eof),
    .rx_data  (rx_data),
    .took     (took),
    .last     (last),
    .cnt      (cnt),
    .word     (word)
  );

  // Event bits gated onto the interrupt line
  event_irq #(
    .W     (32),
    .VALID (EVENT_BITS)
  ) u_irq (
    .clk     (clk),
    .rst     (rst),
    .ev      (ev),
    .clr_wr  (wr && (addr == INT_STAT_ADDR)),
    .mask_wr (wr && (addr == INT_MASK_ADDR)),
    .wdata   (wdata),
    .stat    (int_stat),
    .mask    (int_mask),
    .irq     (irq)
  );

  // Frame checks, flag updates and register port; engine events follow the frame checks so a set beats a clear
  always_comb begin
    s_d       = s_q;
    ev        = 32'h0000_0000;
    s_d.fgood = 1'b0;
    s_d.fdrop = 1'b0;
    s_d.rdata = 32'h0000_0000;

    // A first byte restarts tracking even mid-frame, so a lost end cannot wedge us
    if (took && (cnt == CNT_FIRST)) begin
      s_d.st       = ST_FRAME;
      s_d.addr_bad = 1'b0;
      s_d.hdr_bad  = 1'b0;
      s_d.big      = 1'b0;
    end

    if (took) begin
      case (s_d.st)
        ST_FRAME: begin
          // Destination compare byte by byte, only while checking is on
          if ((cnt <= DA_LEN) && s_q.chk_en && (word[7:0] != mac_byte(switch_mac, cnt - CNT_FIRST))) begin
            s_d.addr_bad = 1'b1;
          end
          if (cnt == TAG_END) begin
            if (word == s_q.tag) begin
              s_d.st     = ST_MGMT;
              // New tagged frame re-arms the flags
              s_d.resp   = 1'b0;
              s_d.exec   = 1'b0;
              s_d.amis   = 1'b0;
              s_d.fmt    = 1'b0;
              s_d.code   = 1'b0;
              s_d.cmd    = 1'b0;
              s_d.over   = 1'b0;
              s_d.loc    = '0;
              s_d.rblock = 1'b0;
              if (s_d.addr_bad) begin
                s_d.amis       = 1'b1;
                ev[AMIS_BIT]   = 1'b1;
              end
            end else begin
              // Not ours; ignore the rest of it
              s_d.st = ST_OTHER;
            end
          end
        end
        ST_MGMT: begin
          if ((cnt == FMT_END) && (word != ACCESS_FORMAT)) begin
            s_d.fmt      = 1'b1;
            s_d.hdr_bad  = 1'b1;
            ev[FMT_BIT]  = 1'b1;
          end
          if ((cnt == CODE_END) && !code_ok(word)) begin
            s_d.code     = 1'b1;
            s_d.hdr_bad  = 1'b1;
            ev[CODE_BIT] = 1'b1;
          end
          // Count includes pad and check sequence bytes as delivered
          if (cnt == (MAX_FRAME + CNT_FIRST)) begin
            s_d.over     = 1'b1;
            s_d.big      = 1'b1;
            s_d.rblock   = 1'b1;
            ev[OVER_BIT] = 1'b1;
          end
        end
        ST_IDLE, ST_OTHER: begin
          // Nothing to check
        end
        default: begin
          s_d.st = ST_IDLE;
        end
      endcase
    end

    // End of frame: report good or discard
    if (last) begin
      if (s_d.st == ST_MGMT) begin
        if (s_d.addr_bad || s_d.hdr_bad || s_d.big) begin
          s_d.fdrop = 1'b1;
        end else begin
          s_d.good     = 1'b1;
          s_d.fgood    = 1'b1;
          ev[GOOD_BIT] = 1'b1;
        end
      end
      s_d.st = ST_IDLE;
    end

    // Engine reports; first bad position is kept until re-armed
    if (cmd_err) begin
      if (!s_d.cmd) begin
        s_d.loc = cmd_err_loc;
      end
      s_d.cmd     = 1'b1;
      ev[CMD_BIT] = 1'b1;
    end
    if (exec_done) begin
      s_d.exec     = 1'b1;
      ev[EXEC_BIT] = 1'b1;
    end
    if (resp_sent) begin
      s_d.resp     = 1'b1;
      ev[RESP_BIT] = 1'b1;
    end

    // Register writes; status is read only
    if (wr && (addr == CTRL_ADDR)) begin
      s_d.chk_en = wdata[CHK_EN_BIT];
      s_d.tag    = wdata[15:0];
    end

    // Register reads, answered next cycle; reads change nothing else
    if (rd) begin
      case (addr)
        CTRL_ADDR: begin
          s_d.rdata             = 32'h0000_0000;
          s_d.rdata[CHK_EN_BIT] = s_q.chk_en;
          s_d.rdata[15:0]       = s_q.tag;
        end
        STATUS_ADDR: begin
          s_d.rdata = status_word(s_q);
        end
        INT_STAT_ADDR: begin
          s_d.rdata = int_stat;
        end
        INT_MASK_ADDR: begin
          s_d.rdata = int_mask;
        end
        default: begin
          // Unmapped reads return zero
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register; control fields take their documented defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.st     <= ST_IDLE;
      s_q.chk_en <= CHK_EN_RESET;
      s_q.tag    <= TAG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata      = s_q.rdata;
  assign frame_good = s_q.fgood;
  assign frame_drop = s_q.fdrop;
  assign resp_block = s_q.rblock;

  // Good frame pulse leaves the status flag set
  a_good_frame_flag: assert property (@(posedge clk) disable iff (rst)
    frame_good |-> s_q.good) else $error("good frame flag not set");

  // Response sent sets the flag next cycle
  a_resp_sent_flag: assert property (@(posedge clk) disable iff (rst)
    resp_sent |=> s_q.resp) else $error("response flag missing");

  // Execution done sets the flag next cycle
  a_exec_done_flag: assert property (@(posedge clk) disable iff (rst)
    exec_done |=> s_q.exec) else $error("execution flag missing");

  // Tag match without new events clears response and execution flags
  a_tag_clears_flags: assert property (@(posedge clk) disable iff (rst)
    (took && s_q.st == ST_FRAME && cnt == TAG_END && cnt != CNT_FIRST && word == s_q.tag
     && !resp_sent && !exec_done) |=> (!s_q.resp && !s_q.exec && !s_q.over)) else $error("flags not re-armed");

  // Mismatch flag rises only with checking enabled
  a_addr_check_gate: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.amis) |-> $past(s_q.chk_en)) else $error("mismatch without check enable");

  // Bad format in a management frame raises the flag
  a_format_error: assert property (@(posedge clk) disable iff (rst)
    (took && s_q.st == ST_MGMT && cnt == FMT_END && word != ACCESS_FORMAT) |=> s_q.fmt)
    else $error("format error missed");

  // Accepted codes never raise the code flag
  a_code_accept: assert property (@(posedge clk) disable iff (rst)
    (took && s_q.st == ST_MGMT && cnt == CODE_END && code_ok(word)) |=> ($stable(s_q.code)))
    else $error("valid access code flagged");

  // Oversize byte forbids the response and flags the error
  a_oversize_block: assert property (@(posedge clk) disable iff (rst)
    (took && s_q.st == ST_MGMT && cnt == (MAX_FRAME + CNT_FIRST)) |=> (s_q.over && resp_block))
    else $error("oversize not blocked");

  // Bad command position latched
  a_cmd_location: assert property (@(posedge clk) disable iff (rst)
    (cmd_err && !s_q.cmd && !(took && cnt == TAG_END)) |=> (s_q.cmd && s_q.loc == $past(cmd_err_loc)))
    else $error("command location wrong");

  // Status read returns the flags with reserved bits zero in the cycle after the strobe
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == STATUS_ADDR) |=> (rdata == status_word($past(s_q)) && rdata[28:15] == 14'h0000 && rdata[9:7] == 3'h0))
    else $error("status read wrong");
endmodule // inband_mgmt_status

/* tb/frame_host.sv */
// Remote management host model that sends command frames byte by byte
`timescale 1ns/1ps
module frame_host (
  input  wire logic clk,
  output logic      rx_valid,
  output logic      rx_sof,
  output logic      rx_eof,
  output logic [7:0] rx_data
);
  // Idle line levels at time zero
  initial begin
    rx_valid = 1'b0;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
    rx_data  = 8'h00;
  end

  // One frame, bytes back to back; fields big endian, zero pad to the end
  task automatic send(input logic [47:0] da, input logic [15:0] tag, input logic [15:0] fmt,
                      input logic [15:0] code, input int len);
    logic [7:0] b;
    int         k;
    b = 8'h00;
    for (k = 0; k < len; k++) begin
      if (k < 6) b = da[8*(5-k) +: 8];
      else if (k < 12) b = 8'h5A;
      else if (k < 14) b = tag[8*(13-k) +: 8];
      else if (k < 16) b = fmt[8*(15-k) +: 8];
      else if (k < 18) b = code[8*(17-k) +: 8];
      else b = 8'h00;  // Zero run and check sequence count toward the size
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_sof   <= (k == 0);
      rx_eof   <= (k == len - 1);
      rx_data  <= b;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_sof   <= 1'b0;
    rx_eof   <= 1'b0;
    rx_data  <= ~b;  // Released line shows the inverse, not a stale byte
  endtask
endmodule // frame_host

/* tb/inband_mgmt_status_test.sv */
// Self-checking bench for the in-band management status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module inband_mgmt_status_test;
  import inband_mgmt_pkg::*;
  localparam logic [47:0] MAC = 48'h0200_0000_0001;  // Any own address works
  localparam logic [31:0] LOCM = 32'hFFFF_FF80;       // Flags without the location field
  logic clk, rst, rx_valid, rx_sof, rx_eof, cmd_err, exec_done, resp_sent, wr, rd;
  logic frame_good, frame_drop, resp_block, irq;
  logic [7:0]  rx_data;
  logic [47:0] switch_mac;
  logic [6:0]  cmd_err_loc;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, v;
  int          mismatches, num_checks, goods, drops;

  inband_mgmt_status inband_mgmt_status_i (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_data(rx_data), .switch_mac(switch_mac), .cmd_err(cmd_err), .cmd_err_loc(cmd_err_loc),
    .exec_done(exec_done), .resp_sent(resp_sent), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .frame_good(frame_good), .frame_drop(frame_drop), .resp_block(resp_block), .irq(irq));
  frame_host frame_host_i (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count the one-cycle result pulses
  always @(posedge clk) begin
    if (frame_good === 1'b1) goods++;
    if (frame_drop === 1'b1) drops++;
  end

  // Register write: one strobe cycle, released at the next edge
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Register read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Frame with the reset tag, then room for the two-cycle flag latency
  task automatic frame(input logic [47:0] da, input logic [15:0] fmt, input logic [15:0] code, input int len);
    frame_host_i.send(da, TAG_RESET, fmt, code, len);
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    rd_reg(STATUS_ADDR, v);
    `CHK("status", 32'h0000_0000, v)
    rd_reg(CTRL_ADDR, v);
    `CHK("ctrl", 32'h0000_40FE, v)
    rd_reg(INT_STAT_ADDR, v);
    `CHK("int_stat", 32'h0000_0000, v)
    rd_reg(16'h0200, v);
    `CHK("unmapped", 32'h0000_0000, v)
    $display("test reset done");
  endtask

  task automatic t_events;
    frame(MAC, ACCESS_FORMAT, ACCESS_CODE_A, 64);
    `CHK("goods", 1, goods)
    rd_reg(STATUS_ADDR, v);
    `CHK("status good", 32'h8000_0000, v)
    @(posedge clk);
    exec_done <= 1'b1;
    resp_sent <= 1'b1;
    cmd_err <= 1'b1;
    cmd_err_loc <= 7'h25;
    @(posedge clk);
    exec_done <= 1'b0;
    resp_sent <= 1'b0;
    cmd_err <= 1'b0;
    wr_reg(STATUS_ADDR, 32'hFFFF_FFFF);
    rd_reg(STATUS_ADDR, v);
    `CHK("status ev", 32'hE000_0825, v)
    rd_reg(STATUS_ADDR, v);
    `CHK("status reread", 32'hE000_0825, v)
    frame(MAC, ACCESS_FORMAT, ACCESS_CODE_B, 64);
    rd_reg(STATUS_ADDR, v);
    `CHK("status clr", 32'h8000_0000, v & LOCM)
    $display("test events done");
  endtask

  task automatic t_header;
    logic [15:0] f[5] = '{16'h9800, 16'h9800, 16'h9801, 16'h9800, 16'h9800};
    logic [15:0] c[5] = '{16'h0001, 16'h0002, 16'h0001, 16'h0000, 16'h0003};
    logic [31:0] e[5] = '{32'h0, 32'h0, 32'h0000_2000, 32'h0000_1000, 32'h0000_1000};
    int          k, d0;
    for (k = 0; k < 5; k++) begin
      d0 = drops;
      frame(MAC, f[k], c[k], 64);
      rd_reg(STATUS_ADDR, v);
      `CHK("status hdr", 32'h8000_0000 | e[k], v & LOCM)
      `CHK("drop hdr", d0 + (e[k] != 0), drops)
    end
    frame_host_i.send(MAC, 16'h1234, 16'h0000, 16'h0000, 64);
    repeat (3) @(posedge clk);
    rd_reg(STATUS_ADDR, v);
    `CHK("foreign tag", 32'h8000_1000, v & LOCM)
    $display("test header done");
  endtask

  task automatic t_addr;
    int d0;
    d0 = drops;
    frame(MAC ^ 48'h1, ACCESS_FORMAT, ACCESS_CODE_A, 64);
    rd_reg(STATUS_ADDR, v);
    `CHK("amis off", 32'h8000_0000, v & LOCM)
    `CHK("drop off", d0, drops)
    wr_reg(CTRL_ADDR, 32'h4000_40FE);
    rd_reg(CTRL_ADDR, v);
    `CHK("ctrl en", 32'h4000_40FE, v)
    frame(MAC ^ 48'h1, ACCESS_FORMAT, ACCESS_CODE_A, 64);
    rd_reg(STATUS_ADDR, v);
    `CHK("amis on", 32'h8000_4000, v & LOCM)
    `CHK("drop on", d0 + 1, drops)
    $display("test address done");
  endtask

  task automatic t_size;
    frame(MAC, ACCESS_FORMAT, ACCESS_CODE_A, 320);
    rd_reg(STATUS_ADDR, v);
    `CHK("size 320", 32'h8000_0000, v & LOCM)
    `CHK("blk 320", 1'b0, resp_block)
    frame(MAC, ACCESS_FORMAT, ACCESS_CODE_A, 321);
    rd_reg(STATUS_ADDR, v);
    `CHK("size 321", 32'h8000_0400, v & LOCM)
    `CHK("blk 321", 1'b1, resp_block)
    frame(MAC, ACCESS_FORMAT, ACCESS_CODE_A, 64);
    `CHK("blk clr", 1'b0, resp_block)
    $display("test size done");
  endtask

  task automatic t_irq;
    rd_reg(INT_STAT_ADDR, v);
    `CHK("int all", EVENT_BITS, v)
    `CHK("irq off", 1'b0, irq)
    wr_reg(INT_MASK_ADDR, 32'h8000_0000);
    #1 `CHK("irq on", 1'b1, irq)
    wr_reg(INT_STAT_ADDR, EVENT_BITS);
    #1 `CHK("irq clr", 1'b0, irq)
    @(posedge clk);
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
    rd_reg(INT_STAT_ADDR, v);
    `CHK("int exec", 32'h2000_0000, v)
    `CHK("irq masked", 1'b0, irq)
    wr_reg(INT_MASK_ADDR, 32'h2000_0000);
    #1 `CHK("irq unmask", 1'b1, irq)
    $display("test interrupt done");
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well above the roughly 1500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  // Main sequence
  initial begin
    {rst, cmd_err, exec_done, resp_sent, wr, rd} = 6'b100000;
    {cmd_err_loc, addr, wdata} = '0;
    switch_mac = MAC;
    {mismatches, num_checks, goods, drops} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_events;
    t_header;
    t_addr;
    t_size;
    t_irq;
    complete_run;
  end
endmodule // inband_mgmt_status_test
